// ==== core/pad_cfg_defines.svh ====
/*
  Offsets, slot numbers, field positions, masks and reset values of the
  port pad configuration register bank.
  Assumes one inclusion per compilation unit; guarded against repeats.
*/
// What this block does
// - Open-drain bit clear gives push-pull, resets clear
// - Open-drain bit set drives the line low only
// - One open-drain bit per line, ports 2,3,4,6,7,8
// - Open-drain registers live in extended register space
// - Level select bits map port bytes 0..7
// - Low-byte bit picks standard or hysteresis levels
// - High-byte bit picks standard or hysteresis levels
// - Direction and output mode ignore threshold choice
// - Two-bit edge-rate field per nibble
// - Two-bit drive-strength field per nibble
// - Edge codes: fast, slow, two reserved
// - Drive codes: max, dynamic, reduced, reserved
// - Nibble fields at bits 1:0,3:2,5:4,7:6
// - Eight-bit port control reads zero high byte
// - Long and short address both reach each register
// - Pins latched into input latch every state time
`ifndef PAD_CFG_DEFINES_SVH
`define PAD_CFG_DEFINES_SVH

// ==========================================================
// Register indices (byte address is four times the index)
`define IDX_OUT_CTRL_P0L 16'hF080
`define IDX_OUT_CTRL_P0H 16'hF082
`define IDX_OUT_CTRL_P1L 16'hF084
`define IDX_OUT_CTRL_P1H 16'hF086
`define IDX_OUT_CTRL_P2 16'hF088
`define IDX_OUT_CTRL_P3 16'hF08A
`define IDX_OUT_CTRL_P4 16'hF08C
`define IDX_OUT_CTRL_P6 16'hF08E
`define IDX_OUT_CTRL_P7 16'hF090
`define IDX_OUT_CTRL_P8 16'hF092
`define IDX_INPUT_LEVEL 16'hF1C4
`define IDX_OD_P2 16'hF1C2
`define IDX_OD_P3 16'hF1C6
`define IDX_OD_P4 16'hF1CA
`define IDX_OD_P6 16'hF1CE
`define IDX_OD_P7 16'hF1D2
`define IDX_OD_P8 16'hF1D6
// Short address n maps to extended index base + 2n
`define EXT_SPACE_BASE 16'hF000

// ==========================================================
// Writable bit masks
`define MASK_BYTE_PORT 16'h00FF
`define MASK_WORD_PORT 16'hFFFF
`define MASK_PORT3 16'hBFFF
`define MASK_INPUT_LEVEL 16'h00DF

// ==========================================================
// Reset values
`define RESET_REG 16'h0000

// ==========================================================
// Timing, bus response codes and empty slot marker
`define STATE_TIME_CYCLES 1
`define AXI_RESP_OKAY 2'h0
`define AXI_RESP_SLVERR 2'h2
`define SLOT_NONE 5'h1F

`endif

// ==== core/pad_cfg_pkg.sv ====
/*
  Types shared by the pad configuration register bank.
  Assumes nothing of its surroundings.
*/
package pad_cfg_pkg;
  // ========================================================
  // Edge-rate field codes
  typedef enum logic [1:0] {
    EDGE_FAST = 2'h0,
    EDGE_SLOW = 2'h1,
    EDGE_RSV2 = 2'h2,
    EDGE_RSV3 = 2'h3
  } edge_code_e;

  // ========================================================
  // Drive-strength field codes
  typedef enum logic [1:0] {
    DRIVE_HIGH = 2'h0,
    DRIVE_DYNAMIC = 2'h1,
    DRIVE_LOW = 2'h2,
    DRIVE_RSV3 = 2'h3
  } drive_code_e;
endpackage

// ==== core/port_pad_config_registers.sv ====
/*
  Pad configuration register bank for the general purpose ports: open-drain
  selects, input threshold selects and per-nibble edge and drive fields,
  reached over an AXI4-Lite slave, with registered pad control outputs.
  Assumes a single clock aclk, synchronous active-low reset, pins arriving
  asynchronously, and port data/direction coming from logic on aclk.
*/
`timescale 1ns/10ps
`include "pad_cfg_defines.svh"

module port_pad_config_registers #(
  parameter int ADDR_W = 18,
  parameter int NIBBLES = 24,
  parameter int LINES = 64
) (
  // Clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // AXI4-Lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  // AXI4-Lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  // AXI4-Lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Port logic on aclk: output data and direction per line
  input wire logic [LINES-1:0] port_out_data,
  input wire logic [LINES-1:0] port_dir_out,
  // Raw pin levels
  input wire logic [LINES-1:0] pin_in,
  // Pad driver controls per line
  output logic [LINES-1:0] pad_out,
  output logic [LINES-1:0] pad_oe,
  output logic [LINES-1:0] pad_open_drain,
  output logic [LINES-1:0] pin_latch,
  // Threshold select per port byte
  output logic [7:0] byte_hysteresis,
  // Per-nibble driver characteristics
  output logic [NIBBLES-1:0] nibble_edge_slow,
  output logic [NIBBLES-1:0] nibble_drive_dynamic,
  output logic [NIBBLES-1:0] nibble_drive_low
);

  localparam int SLOTS = 17;

  // ========================================================
  // Address to register slot
  // Short addresses fold onto the extended space at base + 2n
  function automatic logic [15:0] to_phys(input logic [15:0] idx);
    logic [15:0] p;
    p = idx;
    if (idx[15:8] == 8'h00) begin
      p = `EXT_SPACE_BASE + {7'h00, idx[7:0], 1'b0};
    end
    return p;
  endfunction

  // Slot numbers 0..9 output control, 10 level select, 11..16 open drain
  function automatic logic [4:0] slot_of(input logic [15:0] phys);
    logic [4:0] s;
    s = `SLOT_NONE;
    case (phys)
      `IDX_OUT_CTRL_P0L: s = 5'h00;
      `IDX_OUT_CTRL_P0H: s = 5'h01;
      `IDX_OUT_CTRL_P1L: s = 5'h02;
      `IDX_OUT_CTRL_P1H: s = 5'h03;
      `IDX_OUT_CTRL_P2: s = 5'h04;
      `IDX_OUT_CTRL_P3: s = 5'h05;
      `IDX_OUT_CTRL_P4: s = 5'h06;
      `IDX_OUT_CTRL_P6: s = 5'h07;
      `IDX_OUT_CTRL_P7: s = 5'h08;
      `IDX_OUT_CTRL_P8: s = 5'h09;
      `IDX_INPUT_LEVEL: s = 5'h0A;
      `IDX_OD_P2: s = 5'h0B;
      `IDX_OD_P3: s = 5'h0C;
      `IDX_OD_P4: s = 5'h0D;
      `IDX_OD_P6: s = 5'h0E;
      `IDX_OD_P7: s = 5'h0F;
      `IDX_OD_P8: s = 5'h10;
      default: s = `SLOT_NONE;
    endcase
    return s;
  endfunction

  // Writable bits of each slot; all other bits read as zero
  function automatic logic [15:0] mask_of(input logic [4:0] s);
    logic [15:0] m;
    m = 16'h0000;
    case (s)
      5'h04, 5'h05: m = `MASK_WORD_PORT; // 16-bit ports, four nibbles
      5'h0A: m = `MASK_INPUT_LEVEL;
      5'h0B: m = `MASK_WORD_PORT;
      5'h0C: m = `MASK_PORT3; // Line 14 of port 3 absent
      default: m = (s < 5'h11) ? `MASK_BYTE_PORT : 16'h0000;
    endcase
    return m;
  endfunction

  // ========================================================
  // Register storage and bus state
  logic [15:0] reg_q [0:SLOTS-1];
  logic awready_q;
  logic wready_q;
  logic aw_have_q;
  logic w_have_q;
  logic [15:0] aw_idx_q;
  logic [15:0] w_data_q;
  logic [1:0] w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  // ========================================================
  // Write channel handshakes and commit
  // Address and data may come in either order; the commit waits for both,
  // and the readies stay low until the response is taken, so one write at a time
  wire [15:0] aw_index = awaddr[ADDR_W-1:2]; // Byte address bits 1:0 unused
  wire aw_take = awvalid & awready_q;
  wire w_take = wvalid & wready_q;
  wire do_write = aw_have_q & w_have_q;
  wire [4:0] wr_slot = slot_of(to_phys(aw_idx_q));
  wire wr_hit = (wr_slot != `SLOT_NONE);
  wire [15:0] strb_bits = {{8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
  wire [15:0] wr_mask = mask_of(wr_slot) & strb_bits;
  wire [1:0] wr_resp = wr_hit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR; // Unmapped index refused
  wire aw_have_d = (aw_have_q & ~do_write) | aw_take;
  wire w_have_d = (w_have_q & ~do_write) | w_take;
  wire bvalid_d = do_write | (bvalid_q & ~bready);
  wire awready_d = ~aw_have_d & ~bvalid_d;
  wire wready_d = ~w_have_d & ~bvalid_d;

  // ========================================================
  // Read channel decode
  // Read word built here and registered at the address handshake, so it holds while rready waits
  wire [15:0] ar_index = araddr[ADDR_W-1:2];
  wire ar_take = arvalid & arready_q;
  wire [4:0] rd_slot = slot_of(to_phys(ar_index));
  wire rd_hit = (rd_slot != `SLOT_NONE);
  wire [15:0] rd_val = rd_hit ? (reg_q[rd_slot] & mask_of(rd_slot)) : 16'h0000;
  wire [31:0] rd_word = {16'h0000, rd_val}; // Upper half always zero
  wire [1:0] rd_resp = rd_hit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
  wire rvalid_d = ar_take | (rvalid_q & ~rready);
  wire arready_d = ~rvalid_d;

  // Write address and data held flags
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
    end else if (ce) begin
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
    end
  end

  // Write address and data capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_idx_q <= 16'h0000;
      w_data_q <= 16'h0000;
      w_strb_q <= 2'h0;
    end else if (ce) begin
      if (aw_take) begin
        aw_idx_q <= aw_index;
      end
      if (w_take) begin
        w_data_q <= wdata[15:0];
        w_strb_q <= wstrb[1:0];
      end
    end
  end

  // Write response and ready flags
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= `AXI_RESP_OKAY;
    end else if (ce) begin
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      if (do_write) begin
        bresp_q <= wr_resp;
      end
    end
  end

  // Register array update; reserved edge and drive codes stored as written
  // Only strobed, writable bits change, so unimplemented bits always read zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < SLOTS; i++) begin
        reg_q[i] <= `RESET_REG;
      end
    end else if (ce && do_write && wr_hit) begin
      reg_q[wr_slot] <= (reg_q[wr_slot] & ~wr_mask) | (w_data_q & wr_mask);
    end
  end

  // Read handshake flags
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
    end else if (ce) begin
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
    end
  end

  // Read answer, captured at the address handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdata_q <= 32'h0000_0000;
      rresp_q <= `AXI_RESP_OKAY;
    end else if (ce && ar_take) begin
      rdata_q <= rd_word;
      rresp_q <= rd_resp;
    end
  end

  // ========================================================
  // Flattened views of the stored fields
  // Nibble order: P0L,P0H,P1L,P1H two each, P2,P3 four each, P4,P6,P7,P8 two each
  wire [NIBBLES*4-1:0] nib_fields = {reg_q[9][7:0], reg_q[8][7:0], reg_q[7][7:0], reg_q[6][7:0],
                                     reg_q[5], reg_q[4], reg_q[3][7:0], reg_q[2][7:0],
                                     reg_q[1][7:0], reg_q[0][7:0]};
  // Line order: P2 [15:0], P3 [31:16], P4, P6, P7, P8 one byte each
  wire [15:0] od_p2 = reg_q[11];
  wire [15:0] od_p3 = reg_q[12] & `MASK_PORT3; // Line 14 has no pad
  wire [7:0] od_p4 = reg_q[13][7:0];
  wire [7:0] od_p6 = reg_q[14][7:0];
  wire [7:0] od_p7 = reg_q[15][7:0];
  wire [7:0] od_p8 = reg_q[16][7:0];
  wire [LINES-1:0] od_lines = {od_p8, od_p7, od_p6, od_p4, od_p3, od_p2};
  // Byte order: P2L, P2H, P3L, P3H, P4, P6 (none), P7, P8
  wire [15:0] level_bits = reg_q[10] & `MASK_INPUT_LEVEL;
  wire [7:0] hyst_bytes = level_bits[7:0];

  // Nibble field decode
  logic [NIBBLES-1:0] edge_slow_d;
  logic [NIBBLES-1:0] drive_dyn_d;
  logic [NIBBLES-1:0] drive_low_d;
  for (genvar k = 0; k < NIBBLES; k++) begin : g_nib
    wire [1:0] edge_code = nib_fields[4*k+1 -: 2];
    wire [1:0] drive_code = nib_fields[4*k+3 -: 2];
    // Reserved codes fall back to fast edge and full strength
    assign edge_slow_d[k] = (edge_code == pad_cfg_pkg::EDGE_SLOW);
    assign drive_dyn_d[k] = (drive_code == pad_cfg_pkg::DRIVE_DYNAMIC);
    assign drive_low_d[k] = (drive_code == pad_cfg_pkg::DRIVE_LOW);
  end

  // Line driver decode, independent of threshold selection
  // Open drain: a one releases the pad to the outside pull-up, a zero pulls low
  wire [LINES-1:0] oe_d = port_dir_out & ~(od_lines & port_out_data);
  wire [LINES-1:0] out_d = port_out_data & ~od_lines;

  // ========================================================
  // Pin synchroniser and input latch
  logic [LINES-1:0] pin_meta_q;
  logic [LINES-1:0] pin_sync_q;
  logic [LINES-1:0] pin_latch_q;

  // State-time tick; the latch samples once per state time, in or out
  localparam int ST_CYC = `STATE_TIME_CYCLES;
  localparam int ST_W = (ST_CYC > 1) ? $clog2(ST_CYC) : 1;
  localparam logic [ST_W-1:0] ST_LAST = ST_W'(ST_CYC - 1);
  logic [ST_W-1:0] st_cnt_q;
  wire st_tick = (st_cnt_q == ST_LAST);
  wire [ST_W-1:0] st_cnt_d = st_tick ? ST_W'(0) : st_cnt_q + ST_W'(1);

  // State-time counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_cnt_q <= ST_W'(0);
    end else if (ce) begin
      st_cnt_q <= st_cnt_d;
    end
  end

  // Two-stage synchroniser then state-time latch
  // Pins are asynchronous: only the second stage feeds the latch
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
      pin_latch_q <= '0;
    end else if (ce) begin
      pin_meta_q <= pin_in;
      pin_sync_q <= pin_meta_q;
      if (st_tick) begin
        pin_latch_q <= pin_sync_q;
      end
    end
  end

  // ========================================================
  // Registered pad controls
  logic [LINES-1:0] pad_out_q;
  logic [LINES-1:0] pad_oe_q;
  logic [LINES-1:0] pad_od_q;
  logic [7:0] hyst_q;
  logic [NIBBLES-1:0] edge_slow_q;
  logic [NIBBLES-1:0] drive_dyn_q;
  logic [NIBBLES-1:0] drive_low_q;

  // Line drivers follow data, direction and open-drain selects one cycle later
  // Registered so that pad controls never glitch while the decode settles
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pad_out_q <= '0;
      pad_oe_q <= '0;
      pad_od_q <= '0;
    end else if (ce) begin
      pad_out_q <= out_d;
      pad_oe_q <= oe_d;
      pad_od_q <= od_lines;
    end
  end

  // Static pad settings follow the register contents one cycle later
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hyst_q <= 8'h00;
      edge_slow_q <= '0;
      drive_dyn_q <= '0;
      drive_low_q <= '0;
    end else if (ce) begin
      hyst_q <= hyst_bytes;
      edge_slow_q <= edge_slow_d;
      drive_dyn_q <= drive_dyn_d;
      drive_low_q <= drive_low_d;
    end
  end

  // ========================================================
  // Output ports
  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign pad_out = pad_out_q;
  assign pad_oe = pad_oe_q;
  assign pad_open_drain = pad_od_q;
  assign pin_latch = pin_latch_q;
  assign byte_hysteresis = hyst_q;
  assign nibble_edge_slow = edge_slow_q;
  assign nibble_drive_dynamic = drive_dyn_q;
  assign nibble_drive_low = drive_low_q;

endmodule

// ==== sim/pad_cfg_properties.sv ====
/*
  Checker for the pad configuration register bank, bound to its top.
  Assumes one clock aclk and a synchronous active-low aresetn.
*/
`timescale 1ns/10ps
module pad_cfg_checker #(
  parameter int ADDR_W = 18,
  parameter int NIBBLES = 24,
  parameter int LINES = 64
) (
  // Clock and control
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // Bus handshakes
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  // Pad side
  input wire logic [LINES-1:0] port_out_data,
  input wire logic [LINES-1:0] port_dir_out,
  input wire logic [LINES-1:0] pin_in,
  input wire logic [LINES-1:0] pad_out,
  input wire logic [LINES-1:0] pad_oe,
  input wire logic [LINES-1:0] pad_open_drain,
  input wire logic [LINES-1:0] pin_latch,
  input wire logic [7:0] byte_hysteresis,
  input wire logic [NIBBLES-1:0] nibble_drive_dynamic,
  input wire logic [NIBBLES-1:0] nibble_drive_low
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================================
  // Consecutive cycles with ce high, cleared by reset or ce low, saturating at 7
  logic [2:0] run_q;
  always_ff @(posedge aclk) begin
    if (!aresetn || !ce) begin
      run_q <= 3'h0;
    end else if (run_q != 3'h7) begin
      run_q <= run_q + 3'h1;
    end
  end
  // ==========================================================
  // Bus timing and holding
  a_write_latency: assert property ((awvalid && awready && wvalid && wready && ce) ##1 ce |-> !bvalid ##1 bvalid)
    else $error("write response not two cycles after take");
  a_read_latency: assert property (arvalid && arready && ce |=> rvalid)
    else $error("read data not one cycle after take");
  a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped early");
  // ==========================================================
  // Pad controls
  a_od_low_only: assert property ((pad_out & pad_open_drain) == '0)
    else $error("open-drain line driven high");
  a_push_pull_out: assert property ($past(aresetn) && $past(ce) |-> pad_out == ($past(port_out_data) & ~pad_open_drain))
    else $error("pad data wrong");
  a_oe_follows_dir: assert property ($past(aresetn) && $past(ce)
    |-> pad_oe == ($past(port_dir_out) & ~(pad_open_drain & $past(port_out_data))))
    else $error("pad enable wrong");
  a_pin_latch_delay: assert property (run_q >= 3'h4 |-> pin_latch == $past(pin_in, 3))
    else $error("pin latch not three cycles behind pins");
  a_level_gap: assert property (byte_hysteresis[5] == 1'b0)
    else $error("unused level bit set");
  a_drive_exclusive: assert property ((nibble_drive_dynamic & nibble_drive_low) == '0)
    else $error("two drive modes at once");
  c_write_done: cover property (bvalid && bready);
  c_read_done: cover property (rvalid && rready);
  c_open_drain: cover property (pad_open_drain != '0 && pad_oe != '0);
endmodule

bind port_pad_config_registers pad_cfg_checker #(.ADDR_W(ADDR_W), .NIBBLES(NIBBLES), .LINES(LINES)) u_chk (
  .aclk, .aresetn, .ce, .awvalid, .awready, .wvalid, .wready, .bvalid, .bready, .bresp,
  .arvalid, .arready, .rvalid, .rready, .rdata, .port_out_data, .port_dir_out, .pin_in,
  .pad_out, .pad_oe, .pad_open_drain, .pin_latch, .byte_hysteresis,
  .nibble_drive_dynamic, .nibble_drive_low);

// ==== sim/port_pad_config_registers_tb.sv ====
/*
  Self-checking bench for the pad configuration register bank.
  Assumes the checker is bound on its own; one 20 MHz clock.
*/
`timescale 1ns/10ps
module port_pad_config_registers_tb;
  logic aclk, aresetn, ce, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [17:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [63:0] port_out_data, port_dir_out, pin_in, pad_out, pad_oe, pad_open_drain, pin_latch;
  logic [7:0] byte_hysteresis;
  logic [23:0] nibble_edge_slow, nibble_drive_dynamic, nibble_drive_low;
  logic [63:0] od_exp;
  int fail_count = 0;
  int n_checks = 0;
  logic [15:0] idx_tab [17] = '{16'hF080, 16'hF082, 16'hF084, 16'hF086, 16'hF088, 16'hF08A, 16'hF08C,
    16'hF08E, 16'hF090, 16'hF092, 16'hF1C4, 16'hF1C2, 16'hF1C6, 16'hF1CA, 16'hF1CE, 16'hF1D2, 16'hF1D6};
  logic [15:0] mask_tab [17] = '{16'h00FF, 16'h00FF, 16'h00FF, 16'h00FF, 16'hFFFF, 16'hFFFF, 16'h00FF,
    16'h00FF, 16'h00FF, 16'h00FF, 16'h00DF, 16'hFFFF, 16'hBFFF, 16'h00FF, 16'h00FF, 16'h00FF, 16'h00FF};

  port_pad_config_registers u_dut (.aclk, .aresetn, .ce, .awvalid, .awready, .awaddr, .awprot(3'h0),
    .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
    .arprot(3'h0), .rvalid, .rready, .rdata, .rresp, .port_out_data, .port_dir_out, .pin_in, .pad_out,
    .pad_oe, .pad_open_drain, .pin_latch, .byte_hysteresis, .nibble_edge_slow, .nibble_drive_dynamic,
    .nibble_drive_low);

  // ==========================================================
  // Clock, compare and verdict
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    if (fail_count == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ==========================================================
  // Bus master tasks, entered just after a rising edge
  task automatic wr(input logic [15:0] idx, input logic [15:0] d, input logic [3:0] s, input logic [1:0] er);
    int n;
    n = 0;
    awaddr <= {idx, 2'h0};
    wdata <= {16'h0000, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (n == 50) begin
        fail_count++;
        print_verdict();
      end
    end while (!(bvalid && bready));
    bready <= 1'b0;
    check({62'h0, bresp}, {62'h0, er});
    @(posedge aclk);
  endtask
  task automatic rd(input logic [15:0] idx, input logic [15:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    araddr <= {idx, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (n == 50) begin
        fail_count++;
        print_verdict();
      end
    end while (!(rvalid && rready));
    rready <= 1'b0;
    check({32'h0, rdata}, {48'h0, ed});
    check({62'h0, rresp}, {62'h0, er});
    @(posedge aclk);
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    aresetn = 1'b0;
    ce = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 18'h00000;
    araddr = 18'h00000;
    wdata = 32'h00000000;
    wstrb = 4'h0;
    port_out_data = 64'h5A5A_5A5A_A5A5_A5A5;
    port_dir_out = 64'hFFFF_FFFF_FFFF_FFFF;
    pin_in = 64'h0000_0000_0000_0000;
    od_exp = 64'hFFFF_FFFF_BFFF_FFFF;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    check(pad_oe, port_dir_out);
    check(pad_out, port_out_data);
    for (int i = 0; i < 17; i++) begin
      rd(idx_tab[i], 16'h0000, 2'h0);
      wr(idx_tab[i], 16'hFFFF, 4'h3, 2'h0);
      rd(idx_tab[i], mask_tab[i], 2'h0);
    end
    check(pad_open_drain, od_exp);
    check(pad_out, 64'h0);
    check(pad_oe, ~(od_exp & port_out_data));
    check({56'h0, byte_hysteresis}, 64'hDF);
    check({40'h0, nibble_edge_slow | nibble_drive_dynamic | nibble_drive_low}, 64'h0);
    rd(16'h00E2, 16'h00DF, 2'h0);
    rd(16'h00E1, 16'hFFFF, 2'h0);
    wr(16'hF08A, 16'h1234, 4'h1, 2'h0);
    rd(16'h0045, 16'hFF34, 2'h0);
    wr(16'h1234, 16'hFFFF, 4'h3, 2'h2);
    rd(16'h1234, 16'h0000, 2'h2);
    for (int c = 0; c < 4; c++) begin
      wr(16'h0044, {8{c[1:0]}}, 4'h3, 2'h0);
      rd(16'hF088, {8{c[1:0]}}, 2'h0);
      check({40'h0, nibble_edge_slow}, {52'h0, {4{c == 1}}, 8'h0});
      check({40'h0, nibble_drive_dynamic}, {51'h0, 1'b1, {4{c == 1}}, 8'h0});
      check({40'h0, nibble_drive_low}, {52'h0, {4{c == 2}}, 8'h0});
    end
    wr(16'hF08C, 16'h0049, 4'h3, 2'h0);
    check({40'h0, nibble_edge_slow}, 64'h010000);
    check({40'h0, nibble_drive_dynamic}, 64'h021000);
    check({40'h0, nibble_drive_low}, 64'h010000);
    pin_in <= 64'h3C3C_C3C3_0F0F_F0F0;
    port_dir_out <= 64'h0F0F_0F0F_0F0F_0F0F;
    repeat (4) @(posedge aclk);
    check(pin_latch, 64'h3C3C_C3C3_0F0F_F0F0);
    check(pad_oe, 64'h0F0F_0F0F_0F0F_0F0F & ~(od_exp & port_out_data));
    // Clock enable low freezes latch and pads, then they catch up
    ce <= 1'b0;
    pin_in <= 64'h0000_0000_0000_0000;
    port_out_data <= 64'hFFFF_FFFF_FFFF_FFFF;
    repeat (3) @(posedge aclk);
    check(pin_latch, 64'h3C3C_C3C3_0F0F_F0F0);
    check(pad_out, 64'h0);
    ce <= 1'b1;
    repeat (4) @(posedge aclk);
    check(pin_latch, 64'h0);
    check(pad_out, 64'h0000_0000_4000_0000);
    print_verdict();
  end
endmodule
